// ===== core/uic_defs.svh
// Constants of the UART interrupt and FIFO control block
//
// Summary of operation
// - Receive data interrupt on trigger or character
// - Transmit ready interrupt; enabling while empty fires
// - Line status: overrun at once, errors on readout
// - Mask bits 7:4 need enhanced function bit
// - Interrupt on RTS rising during auto RTS
// - Interrupt on CTS rising during auto CTS
// - Interrupt mask resets to all zeros
// - Source read reports highest pending only
// - Time-out after four chars plus twelve bits
// - Modem status read clears modem and flow interrupts
// - Line status read clears; receive clears below trigger
// - Receive holding read clears time-out
// - Source read or transmit write clears transmit
// - Xoff and special character clear conditions
// - Source read clears wake-up indication
// - Codes for levels one to four
// - Codes for levels five to seven, none
// - Bits 5:4 need enhanced; 7:6 show FIFO enable
// - FIFO enable bit must accompany other bits
// - FIFO reset bits self-clear after pointer reset
// - Bit 3 selects DMA mode of ready pins
// - Transmit trigger field needs enhanced bit
// - Last written trigger applies to both sides
// - Trigger encodings 1, 4, 8, 14 characters
// - Interrupt output driven only when modem bit set
`ifndef UIC_DEFS_SVH
`define UIC_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UIC_OFS_MASK 3'h1
`define UIC_OFS_SRC  3'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UIC_MB_RX    0
`define UIC_MB_TX    1
`define UIC_MB_LSR   2
`define UIC_MB_MSR   3
`define UIC_MB_SLEEP 4
`define UIC_MB_XOFF  5
`define UIC_MB_RTS   6
`define UIC_MB_CTS   7
`define UIC_FB_EN    0
`define UIC_FB_RXRST 1
`define UIC_FB_TXRST 2
`define UIC_FB_DMA   3

// ----------------------------------------
// Source codes and reset values
// ----------------------------------------
`define UIC_CODE_LSR  6'h06
`define UIC_CODE_TOUT 6'h0C
`define UIC_CODE_RX   6'h04
`define UIC_CODE_TX   6'h02
`define UIC_CODE_MSR  6'h00
`define UIC_CODE_XOFF 6'h10
`define UIC_CODE_FLOW 6'h20
`define UIC_CODE_NONE 6'h01
`define UIC_MASK_RST  8'h00
`define UIC_TRIG_RST  2'h0

// ----------------------------------------
// Trigger levels and time-out length
// ----------------------------------------
`define UIC_TRIG_L0    5'h01
`define UIC_TRIG_L1    5'h04
`define UIC_TRIG_L2    5'h08
`define UIC_TRIG_L3    5'h0E
`define UIC_TOUT_CHARS 4
`define UIC_TOUT_BITS  7'h0C

`endif

// ===== core/uic_pkg.sv
// Types of the UART interrupt and FIFO control block
package uic_pkg;

  typedef enum logic [3:0] {
    src_none, src_lsr, src_tout, src_rx, src_tx,
    src_msr, src_xoff, src_flow, src_wake
  } uic_src_t;

  typedef struct packed {
    logic [7:0] mask;
    logic       fifo_en;
    logic       dma;
    logic [1:0] trig;
    logic       rx_rst;
    logic       tx_rst;
    logic       lsr_p;
    logic       tx_p;
    logic       msr_p;
    logic       xoff_p;
    logic       spc_p;
    logic       rts_p;
    logic       cts_p;
    logic       wake_p;
    logic       tout_p;
    logic [6:0] tcnt;
    logic [4:0] tx_lvl_q;
    logic       thr_empty_q;
    logic       tx_over;
    logic       rts_q;
    logic       cts_s1;
    logic       cts_s2;
    logic       cts_q;
    logic [7:0] rdata;
  } uic_state_t;

endpackage

// ===== core/uic_ctrl.sv
// Interrupt mask, interrupt source and FIFO control of one UART channel
//
// Chosen here: the register addresses and strobed register access.
`include "uic_defs.svh"

module uic_ctrl (
  input  wire logic       clock_i,       // Device clock
  input  wire logic       rstn_i,        // Async reset, low
  input  wire logic [2:0] addr_i,        // Register address
  input  wire logic [7:0] wdata_i,       // Write data
  input  wire logic       wr_i,          // Write strobe
  input  wire logic       rd_i,          // Read strobe
  output logic      [7:0] rdata_o,       // Read data, next cycle
  input  wire logic       efr_enh_i,     // Enhanced function bit
  input  wire logic       auto_rts_i,    // Auto RTS on
  input  wire logic       auto_cts_i,    // Auto CTS on
  input  wire logic       mcr_int_en_i,  // Modem control bit 3
  input  wire logic [4:0] rx_lvl_i,      // Receive FIFO count
  input  wire logic [4:0] tx_lvl_i,      // Transmit FIFO count
  input  wire logic       thr_empty_i,   // Transmit holding empty
  input  wire logic       rx_load_i,     // Character received
  input  wire logic       rhr_read_i,    // Receive holding read
  input  wire logic       thr_write_i,   // Transmit holding write
  input  wire logic       overrun_i,     // Overrun detected
  input  wire logic       rx_err_read_i, // Faulty char read out
  input  wire logic       lsr_read_i,    // Line status read
  input  wire logic       msr_change_i,  // Modem status bit 0-3 set
  input  wire logic       msr_read_i,    // Modem status read
  input  wire logic       rts_n_i,       // RTS pin level
  input  wire logic       cts_pin_n_i,   // CTS pin, asynchronous
  input  wire logic       xoff_det_i,    // Xoff received
  input  wire logic       xon_det_i,     // Xon received
  input  wire logic       spc_det_i,     // Special char received
  input  wire logic       wake_i,        // Left sleep mode
  input  wire logic       bit_tick_i,    // One pulse per bit time
  input  wire logic [3:0] char_bits_i,   // Bits per character
  output logic            int_o,         // Interrupt level, high
  output logic            int_oe_o,      // Interrupt drive enable
  output logic            fifo_en_o,     // FIFOs enabled
  output logic            rx_fifo_rst_o, // Receive pointer reset
  output logic            tx_fifo_rst_o, // Transmit pointer reset
  output logic            dma_mode_o,    // DMA mode of ready pins
  output logic      [1:0] trig_sel_o,    // Trigger selection
  output logic            sleep_en_o     // Sleep mode enabled
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  uic_pkg::uic_state_t state_ff;
  uic_pkg::uic_state_t nxt_state;
  uic_pkg::uic_src_t   top;

  logic [4:0] trig_lvl;
  logic       rx_hit;
  logic       wr_mask;
  logic       wr_fcr;
  logic       rd_src;
  logic [7:0] eff_mask;
  logic       e_lsr;
  logic       e_tout;
  logic       e_rx;
  logic       e_tx;
  logic       e_msr;
  logic       e_xoff;
  logic       e_flow;
  logic       e_wake;
  logic       any_int;
  logic [5:0] code;
  logic [6:0] tlim;
  logic       tx_set;
  logic       rts_set;
  logic       cts_set;

  assign wr_mask = wr_i && addr_i == `UIC_OFS_MASK;
  assign wr_fcr  = wr_i && addr_i == `UIC_OFS_SRC;
  assign rd_src  = rd_i && addr_i == `UIC_OFS_SRC;

  always_comb begin
    unique case (state_ff.trig)
      2'h0: trig_lvl = `UIC_TRIG_L0;
      2'h1: trig_lvl = `UIC_TRIG_L1;
      2'h2: trig_lvl = `UIC_TRIG_L2;
      2'h3: trig_lvl = `UIC_TRIG_L3;
    endcase
  end

  // Upper mask bits are kept but act only in enhanced mode
  assign eff_mask = {state_ff.mask[7:4] & {4{efr_enh_i}}, state_ff.mask[3:0]};

  // Receive data is a level, so it clears by itself when reads drain it
  assign rx_hit = state_ff.fifo_en ? (rx_lvl_i >= trig_lvl)
                                   : (rx_lvl_i != 5'h00);

  // ----------------------------------------
  // Priority of enabled pending sources
  // ----------------------------------------
  assign e_lsr  = eff_mask[`UIC_MB_LSR] && state_ff.lsr_p;
  assign e_tout = eff_mask[`UIC_MB_RX] && state_ff.tout_p;
  assign e_rx   = eff_mask[`UIC_MB_RX] && rx_hit;
  assign e_tx   = eff_mask[`UIC_MB_TX] && state_ff.tx_p;
  assign e_msr  = eff_mask[`UIC_MB_MSR] && state_ff.msr_p;
  assign e_xoff = eff_mask[`UIC_MB_XOFF] && (state_ff.xoff_p || state_ff.spc_p);
  assign e_flow = (eff_mask[`UIC_MB_RTS] && state_ff.rts_p)
               || (eff_mask[`UIC_MB_CTS] && state_ff.cts_p);
  assign e_wake = eff_mask[`UIC_MB_SLEEP] && state_ff.wake_p;
  assign any_int = e_lsr || e_tout || e_rx || e_tx || e_msr
                || e_xoff || e_flow || e_wake;

  always_comb begin
    if (e_lsr) begin
      top = uic_pkg::src_lsr;
    end else if (e_tout) begin
      top = uic_pkg::src_tout;
    end else if (e_rx) begin
      top = uic_pkg::src_rx;
    end else if (e_tx) begin
      top = uic_pkg::src_tx;
    end else if (e_msr) begin
      top = uic_pkg::src_msr;
    end else if (e_xoff) begin
      top = uic_pkg::src_xoff;
    end else if (e_flow) begin
      top = uic_pkg::src_flow;
    end else if (e_wake) begin
      top = uic_pkg::src_wake;
    end else begin
      top = uic_pkg::src_none;
    end
  end

  always_comb begin
    unique case (top)
      uic_pkg::src_lsr:  code = `UIC_CODE_LSR;
      uic_pkg::src_tout: code = `UIC_CODE_TOUT;
      uic_pkg::src_rx:   code = `UIC_CODE_RX;
      uic_pkg::src_tx:   code = `UIC_CODE_TX;
      uic_pkg::src_msr:  code = `UIC_CODE_MSR;
      uic_pkg::src_xoff: code = `UIC_CODE_XOFF;
      uic_pkg::src_flow: code = `UIC_CODE_FLOW;
      uic_pkg::src_wake: code = `UIC_CODE_NONE;
      uic_pkg::src_none: code = `UIC_CODE_NONE;
      default:           code = `UIC_CODE_NONE;
    endcase
  end

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  assign tlim = 7'({3'h0, char_bits_i} * `UIC_TOUT_CHARS) + `UIC_TOUT_BITS;

  // Fall below trigger, or empty when the last reload stayed at or under it
  always_comb begin
    if (state_ff.fifo_en) begin
      tx_set = (state_ff.tx_lvl_q >= trig_lvl && tx_lvl_i < trig_lvl
                && state_ff.tx_over)
            || (state_ff.tx_lvl_q != 5'h00 && tx_lvl_i == 5'h00
                && !state_ff.tx_over);
    end else begin
      tx_set = thr_empty_i && !state_ff.thr_empty_q;
    end
    if (wr_mask && wdata_i[`UIC_MB_TX] && !state_ff.mask[`UIC_MB_TX]
        && thr_empty_i) begin
      tx_set = 1'b1;
    end
  end

  assign rts_set = auto_rts_i && rts_n_i && !state_ff.rts_q;
  assign cts_set = auto_cts_i && state_ff.cts_s2 && !state_ff.cts_q;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rx_rst = 1'b0;
    nxt_state.tx_rst = 1'b0;
    nxt_state.rdata  = 8'h00;

    if (wr_mask) begin
      nxt_state.mask = wdata_i;
    end

    if (wr_fcr) begin
      nxt_state.fifo_en = wdata_i[`UIC_FB_EN];
      // Without the enable bit every other bit of the write is dropped
      if (wdata_i[`UIC_FB_EN]) begin
        nxt_state.rx_rst = wdata_i[`UIC_FB_RXRST];
        nxt_state.tx_rst = wdata_i[`UIC_FB_TXRST];
        nxt_state.dma    = wdata_i[`UIC_FB_DMA];
        nxt_state.trig   = wdata_i[7:6];
        if (efr_enh_i) begin
          nxt_state.trig = wdata_i[5:4];
        end
      end
    end

    if (rd_i) begin
      unique case (addr_i)
        `UIC_OFS_MASK: nxt_state.rdata = state_ff.mask;
        `UIC_OFS_SRC:  nxt_state.rdata = {{2{state_ff.fifo_en}}, code};
        default:       nxt_state.rdata = 8'h00;
      endcase
    end

    // Set wins over clear for every sticky source
    nxt_state.lsr_p = overrun_i || rx_err_read_i
                   || (state_ff.lsr_p && !lsr_read_i);
    nxt_state.tx_p = tx_set || (state_ff.tx_p && !thr_write_i
                   && !(rd_src && top == uic_pkg::src_tx));
    nxt_state.msr_p = msr_change_i || (state_ff.msr_p && !msr_read_i);
    nxt_state.rts_p = rts_set || (state_ff.rts_p && !msr_read_i);
    nxt_state.cts_p = cts_set || (state_ff.cts_p && !msr_read_i);
    nxt_state.xoff_p = xoff_det_i || (state_ff.xoff_p && !xon_det_i
                    && !(rd_src && top == uic_pkg::src_xoff));
    nxt_state.spc_p = spc_det_i || (state_ff.spc_p && !rx_load_i
                   && !(rd_src && top == uic_pkg::src_xoff));
    nxt_state.wake_p = wake_i || (state_ff.wake_p
                    && !(rd_src && top == uic_pkg::src_wake));

    // Time-out counts bit times while data waits, restarted by traffic
    if (rx_load_i || rhr_read_i || !state_ff.fifo_en
        || rx_lvl_i == 5'h00) begin
      nxt_state.tcnt = 7'h00;
    end else if (bit_tick_i && state_ff.tcnt != tlim) begin
      nxt_state.tcnt = state_ff.tcnt + 7'h01;
    end
    nxt_state.tout_p = (nxt_state.tcnt == tlim && state_ff.tcnt != tlim)
                    || (state_ff.tout_p && !rhr_read_i);

    if (tx_lvl_i > trig_lvl) begin
      nxt_state.tx_over = 1'b1;
    end else if (tx_lvl_i == 5'h00) begin
      nxt_state.tx_over = 1'b0;
    end
    nxt_state.tx_lvl_q    = tx_lvl_i;
    nxt_state.thr_empty_q = thr_empty_i;
    nxt_state.rts_q       = rts_n_i;
    nxt_state.cts_s1      = cts_pin_n_i;
    nxt_state.cts_s2      = state_ff.cts_s1;
    nxt_state.cts_q       = state_ff.cts_s2;
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= '0;
      state_ff.mask    <= `UIC_MASK_RST;
      state_ff.trig    <= `UIC_TRIG_RST;
      state_ff.rts_q   <= 1'b1;
      state_ff.cts_s1  <= 1'b1;
      state_ff.cts_s2  <= 1'b1;
      state_ff.cts_q   <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o       = state_ff.rdata;
  assign int_o         = any_int;
  assign int_oe_o      = mcr_int_en_i;
  assign fifo_en_o     = state_ff.fifo_en;
  assign rx_fifo_rst_o = state_ff.rx_rst;
  assign tx_fifo_rst_o = state_ff.tx_rst;
  assign dma_mode_o    = state_ff.dma;
  assign trig_sel_o    = state_ff.trig;
  assign sleep_en_o    = eff_mask[`UIC_MB_SLEEP];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n);

  sequence s_rx_reset;
    wr_fcr && wdata_i[`UIC_FB_EN] && wdata_i[`UIC_FB_RXRST];
  endsequence

  sequence s_pulse_once;
    rx_fifo_rst_o ##1 !rx_fifo_rst_o;
  endsequence

  a_mask_after_reset: assert property (
    $rose(rst_n) |-> state_ff.mask == 8'h00)
    else $error("mask not clear after reset");

  a_rx_reset_pulse: assert property (
    s_rx_reset |=> s_pulse_once)
    else $error("receive reset not a single pulse");

  a_fcr_ignored: assert property (
    wr_fcr && !wdata_i[`UIC_FB_EN]
    |=> !fifo_en_o && trig_sel_o == $past(trig_sel_o)
        && dma_mode_o == $past(dma_mode_o))
    else $error("fifo control bits taken without enable");

  a_lsr_code: assert property (
    e_lsr |-> code == 6'h06 && int_o)
    else $error("line status code wrong");

  a_none_code: assert property (
    !any_int |-> code == 6'h01)
    else $error("idle code wrong");

  a_src_high_bits: assert property (
    rd_src |=> rdata_o[7:6] == {2{fifo_en_o}} && rdata_o[5:0] == $past(code))
    else $error("source read data wrong");

  a_tx_on_enable: assert property (
    wr_mask && wdata_i[1] && !state_ff.mask[1] && thr_empty_i
    |=> state_ff.tx_p && int_o)
    else $error("transmit interrupt missing on enable");

  a_overrun_int: assert property (
    overrun_i && state_ff.mask[2] && !wr_mask |=> int_o ##0 code == 6'h06)
    else $error("overrun did not interrupt");

  a_msr_clear: assert property (
    msr_read_i && !msr_change_i && !rts_set && !cts_set
    |=> !state_ff.msr_p && !state_ff.rts_p && !state_ff.cts_p)
    else $error("modem status read did not clear");

  a_enh_gate: assert property (
    !efr_enh_i |-> !sleep_en_o && top != uic_pkg::src_flow
                   && top != uic_pkg::src_xoff)
    else $error("enhanced source active without enable");

  a_lsr_read_clear: assert property (
    lsr_read_i && !overrun_i && !rx_err_read_i |=> !state_ff.lsr_p)
    else $error("line status read did not clear");

  a_tout_read_clear: assert property (
    rhr_read_i |=> !state_ff.tout_p)
    else $error("receive holding read did not clear time-out");

  a_thr_write_clear: assert property (
    thr_write_i && !tx_set |=> !state_ff.tx_p)
    else $error("transmit holding write did not clear");

  a_spc_load_clear: assert property (
    rx_load_i && !spc_det_i |=> !state_ff.spc_p)
    else $error("special character not cleared by next character");

  a_wake_read_clear: assert property (
    rd_src && top == uic_pkg::src_wake && !wake_i |=> !state_ff.wake_p)
    else $error("wake-up indication not cleared by source read");

  a_cts_rise_int: assert property (
    auto_cts_i && $rose(state_ff.cts_s2) |=> state_ff.cts_p)
    else $error("CTS rise did not latch");

  a_tx_fall_trig: assert property (
    fifo_en_o && state_ff.tx_over && $past(tx_lvl_i) >= trig_lvl
    && tx_lvl_i < trig_lvl |=> state_ff.tx_p)
    else $error("transmit fall below trigger missed");

  a_trig_top_level: assert property (
    trig_sel_o == 2'h3 |-> trig_lvl == 5'h0E)
    else $error("top trigger level wrong");

endmodule

// ===== verification/uic_host_model.sv
// Host processor model that drives the register bus of the block
module uic_host_model (
  input  wire logic       clock_i, // Bus clock
  output logic      [2:0] addr_o,  // Register address
  output logic      [7:0] wdata_o, // Write data
  output logic            wr_o,    // Write strobe
  output logic            rd_o     // Read strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr_o  = 3'h0;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Strobes last one cycle; the slave never stalls, so no wait loop
  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clock_i);
    wr_o    <= 1'b0;
    #1;
  endtask

  task automatic read_reg(input logic [2:0] a);
    @(posedge clock_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clock_i);
    rd_o   <= 1'b0;
    #1;
  endtask
endmodule

// ===== verification/uart_interrupt_fifo_control_tb.sv
// Self-checking testbench of the UART interrupt and FIFO control block
module uart_interrupt_fifo_control_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        enhanced_feature_register    = 1'b0;
  logic        arts   = 1'b0;
  logic        acts   = 1'b0;
  logic        modem_control_register    = 1'b0;
  logic [4:0]  rx_lvl = 5'h00;
  logic        thr_e  = 1'b0;
  logic        btick  = 1'b0;
  logic        rts    = 1'b0;
  logic        cts    = 1'b0;
  logic [4:0]  tx_lvl = 5'h00;
  logic [11:0] ev     = 12'h000;
  logic        rd_seen = 1'b0;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        int_o;
  logic        int_oe;
  logic        fifo_en;
  logic        rxrst;
  logic        txrst;
  logic        dma;
  logic [1:0]  trig;
  logic        sleep_en;
  logic [7:0]  exp_q[$];
  logic [7:0]  v;
  int          fail_count = 0;
  int          n_checks   = 0;

  always #2.5 clk = ~clk;

  uic_host_model host (.clock_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  uic_ctrl dut (
    .clock_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .efr_enh_i(enhanced_feature_register), .auto_rts_i(arts),
    .auto_cts_i(acts), .mcr_int_en_i(modem_control_register), .rx_lvl_i(rx_lvl), .tx_lvl_i(tx_lvl),
    .thr_empty_i(thr_e), .rx_load_i(ev[0]), .rhr_read_i(ev[1]),
    .thr_write_i(ev[2]), .overrun_i(ev[3]), .rx_err_read_i(ev[4]),
    .lsr_read_i(ev[5]), .msr_change_i(ev[6]), .msr_read_i(ev[7]),
    .rts_n_i(rts), .cts_pin_n_i(cts), .xoff_det_i(ev[8]), .xon_det_i(ev[9]),
    .spc_det_i(ev[10]), .wake_i(ev[11]), .bit_tick_i(btick),
    .char_bits_i(4'hA), .int_o(int_o), .int_oe_o(int_oe), .fifo_en_o(fifo_en),
    .rx_fifo_rst_o(rxrst), .tx_fifo_rst_o(txrst), .dma_mode_o(dma),
    .trig_sel_o(trig), .sleep_en_o(sleep_en)
  );

  // ----------------------------------------
  // Checking and helpers
  // ----------------------------------------
  task automatic see(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen) begin
      see(rdata, exp_q.pop_front());
    end
  end

  task automatic rd_r(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.read_reg(a);
  endtask

  task automatic wr_r(input logic [2:0] a, input logic [7:0] d);
    host.write_reg(a, d);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev    <= 12'h000;
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  initial begin
    #50us;
    fail_count++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(98));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tick(4);
    see(int_o, 0);
    see(int_oe, 0);
    rd_r(3'h1, 8'h00);
    rd_r(3'h2, 8'h01);
    rd_r(3'h5, 8'h00);
    @(posedge clk) modem_control_register <= 1'b1;
    tick(1);
    see(int_oe, 1);
    @(posedge clk) enhanced_feature_register <= 1'b1;
    repeat (4) begin
      v = 8'($urandom());
      wr_r(3'h1, v);
      rd_r(3'h1, v);
    end
    @(posedge clk) enhanced_feature_register <= 1'b0;
    wr_r(3'h1, 8'hF0);
    see(sleep_en, 0);
    @(posedge clk) enhanced_feature_register <= 1'b1;
    tick(1);
    see(sleep_en, 1);
    wr_r(3'h1, 8'h00);
    @(posedge clk) thr_e <= 1'b1;
    tick(2);
    see(int_o, 0);
    wr_r(3'h1, 8'h02);
    tick(1);
    see(int_o, 1);
    rd_r(3'h2, 8'h02);
    rd_r(3'h2, 8'h01);
    see(int_o, 0);
    @(posedge clk) thr_e <= 1'b0;
    tick(2);
    @(posedge clk) thr_e <= 1'b1;
    tick(2);
    see(int_o, 1);
    pulse(2);
    see(int_o, 0);
    wr_r(3'h1, 8'h0C);
    pulse(3);
    pulse(6);
    see(int_o, 1);
    rd_r(3'h2, 8'h06);
    rd_r(3'h2, 8'h06);
    pulse(5);
    rd_r(3'h2, 8'h00);
    pulse(7);
    see(int_o, 0);
    pulse(4);
    rd_r(3'h2, 8'h06);
    pulse(5);
    rd_r(3'h2, 8'h01);
    wr_r(3'h2, 8'h03);
    see(fifo_en, 1);
    see(rxrst, 1);
    see(txrst, 0);
    tick(1);
    see(rxrst, 0);
    wr_r(3'h2, 8'h05);
    see(txrst, 1);
    wr_r(3'h2, 8'h09);
    see(dma, 1);
    wr_r(3'h2, 8'h08);
    see(fifo_en, 0);
    see(dma, 1);
    rd_r(3'h2, 8'h01);
    wr_r(3'h2, 8'h01);
    see(dma, 0);
    rd_r(3'h2, 8'hC1);
    @(posedge clk) enhanced_feature_register <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      wr_r(3'h2, {t[1:0], 6'h01});
      see({6'h00, trig}, 8'(t));
    end
    wr_r(3'h2, 8'h31);
    see(trig, 0);
    @(posedge clk) enhanced_feature_register <= 1'b1;
    wr_r(3'h2, 8'h21);
    see(trig, 2);
    @(posedge clk) enhanced_feature_register <= 1'b0;
    wr_r(3'h2, 8'hC1);
    see(trig, 3);
    @(posedge clk) enhanced_feature_register <= 1'b1;
    wr_r(3'h2, 8'h11);
    see(trig, 1);
    wr_r(3'h1, 8'h01);
    @(posedge clk) rx_lvl <= 5'h03;
    tick(2);
    see(int_o, 0);
    @(posedge clk) rx_lvl <= 5'h04;
    tick(2);
    see(int_o, 1);
    rd_r(3'h2, 8'hC4);
    @(posedge clk) rx_lvl <= 5'h03;
    tick(2);
    see(int_o, 0);
    // Ten-bit characters: expiry after 52 bit ticks
    @(posedge clk) btick <= 1'b1;
    tick(40);
    see(int_o, 0);
    tick(20);
    @(posedge clk) btick <= 1'b0;
    tick(1);
    see(int_o, 1);
    rd_r(3'h2, 8'hCC);
    pulse(1);
    see(int_o, 0);
    @(posedge clk) rx_lvl <= 5'h00;
    wr_r(3'h1, 8'hE0);
    pulse(8);
    rd_r(3'h2, 8'hD0);
    rd_r(3'h2, 8'hC1);
    pulse(8);
    pulse(9);
    rd_r(3'h2, 8'hC1);
    pulse(10);
    pulse(0);
    rd_r(3'h2, 8'hC1);
    pulse(10);
    rd_r(3'h2, 8'hD0);
    rd_r(3'h2, 8'hC1);
    @(posedge clk) acts <= 1'b1;
    @(posedge clk) cts <= 1'b1;
    tick(5);
    see(int_o, 1);
    rd_r(3'h2, 8'hE0);
    pulse(7);
    rd_r(3'h2, 8'hC1);
    @(posedge clk) arts <= 1'b1;
    @(posedge clk) rts <= 1'b1;
    tick(2);
    rd_r(3'h2, 8'hE0);
    pulse(7);
    @(posedge clk) enhanced_feature_register <= 1'b0;
    @(posedge clk) rts <= 1'b0;
    tick(2);
    @(posedge clk) rts <= 1'b1;
    tick(2);
    see(int_o, 0);
    pulse(7);
    // FIFO transmit: fall below level four, then empty after a low reload
    @(posedge clk) thr_e <= 1'b0;
    tx_lvl <= 5'h06;
    wr_r(3'h1, 8'h02);
    @(posedge clk) tx_lvl <= 5'h04;
    tick(2);
    see(int_o, 0);
    @(posedge clk) tx_lvl <= 5'h03;
    tick(2);
    see(int_o, 1);
    rd_r(3'h2, 8'hC2);
    @(posedge clk) tx_lvl <= 5'h00;
    @(posedge clk) tx_lvl <= 5'h02;
    tick(2);
    see(int_o, 0);
    @(posedge clk) tx_lvl <= 5'h00;
    tick(2);
    see(int_o, 1);
    rd_r(3'h2, 8'hC2);
    @(posedge clk) enhanced_feature_register <= 1'b1;
    wr_r(3'h1, 8'h10);
    pulse(11);
    see(int_o, 1);
    rd_r(3'h2, 8'hC1);
    see(int_o, 0);
    tick(3);
    see(8'(exp_q.size()), 0);
    report_and_stop();
  end
endmodule
